// file: core/bss_defs.svh
// constants for the buck supervisor sequencer
`ifndef BSS_DEFS_SVH
`define BSS_DEFS_SVH
`define BSS_CLK_MHZ        20
`define BSS_PHASE_US       425
`define BSS_PHASE_CYC      (`BSS_PHASE_US * `BSS_CLK_MHZ)
`define BSS_LAST_PHASE     3'h4
`define BSS_UV_IGN_US      10000
`define BSS_UV_IGN_CYC     (`BSS_UV_IGN_US * `BSS_CLK_MHZ)
`define BSS_BLANK_LONG_US  140
`define BSS_BLANK_MID_US   90
`define BSS_BLANK_SHORT_US 40
`define BSS_BLANK_LONG_CYC  12'(`BSS_BLANK_LONG_US * `BSS_CLK_MHZ)
`define BSS_BLANK_MID_CYC   12'(`BSS_BLANK_MID_US * `BSS_CLK_MHZ)
`define BSS_BLANK_SHORT_CYC 12'(`BSS_BLANK_SHORT_US * `BSS_CLK_MHZ)
`define BSS_LVL_GND        2'h0
`define BSS_LVL_REF        2'h1
`define BSS_LVL_OPEN       2'h2
`define BSS_LVL_SUPPLY     2'h3
`define BSS_REG_CTRL       8'h00
`define BSS_REG_STATUS     8'h04
`define BSS_CTRL_RUN_BIT   0
`define BSS_CTRL_RST       32'h00000001
`define BSS_CTRL_RUN_RST   1'b1
`endif

// file: core/bss_pkg.sv
// types for the buck supervisor sequencer
`default_nettype none
package bss_pkg;
  typedef enum logic [2:0] {
    ST_LOCKOUT, ST_SOFTSTART, ST_RUN, ST_DISCHARGE, ST_CLAMP, ST_OFF, ST_OVP_TRIP
  } bss_state_t;
  typedef struct packed {
    logic dis;
    logic under_voltage_trip;
    logic over_voltage_trip;
  } bss_prot_t;
endpackage
`default_nettype wire

// file: core/bss_sync.sv
// two-flop synchronisers for the comparator inputs
`default_nettype none
module bss_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_r;
      logic sync_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= d[i];
          sync_r <= meta_r;
        end
      end
      assign q[i] = sync_r;
    end
  endgenerate
endmodule
`default_nettype wire

// file: core/bss_timer.sv
// retriggerable down-counter for forced switching and blanking
`default_nettype none
module bss_timer (
  input  wire logic  pclk,
  input  wire logic  presetn,
  bss_timer_if.timer tif
);
  logic [11:0] cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 12'h000;
    end else if (tif.load) begin
      cnt_r <= tif.count;
    end else if (cnt_r != 12'h000) begin
      cnt_r <= cnt_r - 12'h001;
    end
  end
  assign tif.active = (cnt_r != 12'h000);
endmodule
`default_nettype wire

// file: core/bss_timer_if.sv
// link between the sequencer and its blanking timer
`default_nettype none
interface bss_timer_if;
  logic        load;
  logic [11:0] count;
  logic        active;
  modport owner (output load, output count, input active);
  modport timer (input load, input count, output active);
endinterface
`default_nettype wire

// file: core/bss_top.sv
// supervisor and sequencer top with apb registers
//
// The APB register port and the register addresses were decided locally.
`include "bss_defs.svh"
`default_nettype none
module bss_top #(
  parameter int unsigned PHASE_CYC  = `BSS_PHASE_CYC,
  parameter int unsigned UV_IGN_CYC = `BSS_UV_IGN_CYC
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic            pready,
  output logic            pslverr,
  input  wire logic       shutdown_request_n,
  input  wire logic       supply_ok_in,
  input  wire logic       level_step_in,
  input  wire logic [1:0] protection_select,
  input  wire logic [1:0] blanking_select,
  input  wire logic       in_regulation_in,
  input  wire logic       window_ok_in,
  input  wire logic       over_voltage_in,
  input  wire logic       under_voltage_in,
  input  wire logic       below_clamp_in,
  input  wire logic       thermal_fault_in,
  input  wire logic       high_side_off_in,
  input  wire logic       low_side_off_in,
  input  wire logic       pwm_high_req,
  input  wire logic       pwm_low_req,
  output logic            high_side_gate_drive,
  output logic            low_side_gate_drive,
  output logic            power_good_out,
  output logic            power_good_oe,
  output logic      [2:0] current_limit_step,
  output logic            modulator_en,
  output logic            reference_en,
  output logic            discharge_en,
  output logic            force_continuous
);
  import bss_pkg::*;

  localparam int PW = $clog2(PHASE_CYC + 1);
  localparam int UW = $clog2(UV_IGN_CYC + 1);

  function automatic bss_prot_t prot_decode(input logic [1:0] sel);
    bss_prot_t p;
    p = '0;
    if (sel == `BSS_LVL_SUPPLY) begin
      p = '{dis: 1'b1, under_voltage_trip: 1'b1, over_voltage_trip: 1'b1};
    end else if (sel == `BSS_LVL_OPEN) begin
      p = '{dis: 1'b1, under_voltage_trip: 1'b0, over_voltage_trip: 1'b1};
    end else if (sel == `BSS_LVL_REF) begin
      p = '{dis: 1'b0, under_voltage_trip: 1'b1, over_voltage_trip: 1'b0};
    end
    return p;
  endfunction

  function automatic logic [12:0] blank_decode(input logic [1:0] sel);
    logic [12:0] b;
    b = {1'b0, `BSS_BLANK_MID_CYC};
    if (sel == `BSS_LVL_SUPPLY) begin
      b = {1'b1, `BSS_BLANK_LONG_CYC};
    end else if (sel == `BSS_LVL_OPEN) begin
      b = {1'b1, `BSS_BLANK_MID_CYC};
    end else if (sel == `BSS_LVL_REF) begin
      b = {1'b1, `BSS_BLANK_SHORT_CYC};
    end
    return b;
  endfunction

  // synchronised comparator and pin levels
  logic [10:0] raw_s;
  logic        thermal_s, supply_s, clamp_s, under_s, over_s, window_s;
  logic        in_reg_s, step_s, shutdown_request_n_s, hs_off_s, ls_off_s;

  bss_sync #(.W(11)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({thermal_fault_in, supply_ok_in, below_clamp_in, under_voltage_in,
               over_voltage_in, window_ok_in, in_regulation_in, level_step_in,
               shutdown_request_n, high_side_off_in, low_side_off_in}),
    .q       (raw_s)
  );
  assign {thermal_s, supply_s, clamp_s, under_s, over_s, window_s,
          in_reg_s, step_s, shutdown_request_n_s, hs_off_s, ls_off_s} = raw_s;

  bss_timer_if tif ();
  bss_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .tif     (tif)
  );

  bss_state_t     state_r, state_nxt;
  bss_prot_t      prot_live;
  logic           dis_r, fault_r, fault_nxt;
  logic           cause_ovp_r, cause_uvp_r, cause_th_r;
  logic           ctrl_run_r, run_req, start_go;
  logic [2:0]     phase_r;
  logic [PW-1:0]  ph_cnt_r;
  logic [UW-1:0]  ign_cnt_r;
  logic           step_d_r, blank_en, blank_act;
  logic [12:0]    blank_cfg;
  logic           active_st, ovp_hit, uvp_hit, th_hit;
  logic           hs_want, ls_want;
  logic           hs_drive_r, ls_drive_r, pg_pull_r;
  logic [2:0]     hs_hist_r, ls_hist_r;
  logic           hs_go;

  assign prot_live = prot_decode(protection_select);
  assign blank_cfg = blank_decode(blanking_select);
  assign blank_en  = blank_cfg[12];
  assign blank_act = blank_en && tif.active;
  assign run_req   = shutdown_request_n_s && ctrl_run_r;
  assign active_st = (state_r == ST_SOFTSTART) || (state_r == ST_RUN);
  assign ovp_hit   = active_st && prot_live.over_voltage_trip && over_s && !blank_act;
  assign uvp_hit   = active_st && prot_live.under_voltage_trip && under_s && !blank_act
                     && (ign_cnt_r == '0);
  assign th_hit    = active_st && thermal_s;
  assign start_go  = (state_nxt == ST_SOFTSTART) && (state_r != ST_SOFTSTART);

  // level-step edges retrigger the forced-switching timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_d_r <= 1'b0;
    end else begin
      step_d_r <= step_s;
    end
  end
  assign tif.load  = step_s ^ step_d_r;
  assign tif.count = blank_cfg[11:0];

  // sequencing state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_LOCKOUT: begin
        if (supply_s && run_req && !fault_r) state_nxt = ST_SOFTSTART;
      end
      ST_SOFTSTART, ST_RUN: begin
        if (!supply_s) begin
          state_nxt = ST_LOCKOUT;
        end else if (th_hit || uvp_hit) begin
          state_nxt = ST_DISCHARGE;
        end else if (ovp_hit) begin
          state_nxt = ST_OVP_TRIP;
        end else if (!run_req) begin
          state_nxt = dis_r ? ST_DISCHARGE : ST_OFF;
        end else if (state_r == ST_SOFTSTART &&
                     (in_reg_s || phase_r == `BSS_LAST_PHASE)) begin
          state_nxt = ST_RUN;
        end
      end
      ST_DISCHARGE: begin
        if (clamp_s) begin
          state_nxt = ST_CLAMP;
        end else if (run_req && supply_s && !fault_r) begin
          state_nxt = ST_SOFTSTART;
        end
      end
      default: begin
        if (run_req && supply_s && !fault_r) state_nxt = ST_SOFTSTART;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_LOCKOUT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // discharge mode sampled at each startup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dis_r <= 1'b0;
    end else if (start_go) begin
      dis_r <= prot_live.dis;
    end
  end

  // fault latch: a new fault wins over the clear
  assign fault_nxt = (ovp_hit || uvp_hit || th_hit) ? 1'b1 :
                     (!run_req ? 1'b0 : fault_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r     <= 1'b0;
      cause_ovp_r <= 1'b0;
      cause_uvp_r <= 1'b0;
      cause_th_r  <= 1'b0;
    end else begin
      fault_r     <= fault_nxt;
      cause_ovp_r <= ovp_hit || (cause_ovp_r && fault_nxt);
      cause_uvp_r <= uvp_hit || (cause_uvp_r && fault_nxt);
      cause_th_r  <= th_hit || (cause_th_r && fault_nxt);
    end
  end

  // soft-start phase counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r  <= 3'h0;
      ph_cnt_r <= '0;
    end else if (start_go) begin
      phase_r  <= 3'h0;
      ph_cnt_r <= '0;
    end else if (state_r == ST_SOFTSTART) begin
      if (ph_cnt_r == PW'(PHASE_CYC - 1)) begin
        ph_cnt_r <= '0;
        if (phase_r != `BSS_LAST_PHASE) phase_r <= phase_r + 3'h1;
      end else begin
        ph_cnt_r <= ph_cnt_r + PW'(1);
      end
    end
  end

  // undervoltage ignore window after start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ign_cnt_r <= '0;
    end else if (start_go) begin
      ign_cnt_r <= UW'(UV_IGN_CYC);
    end else if (ign_cnt_r != '0) begin
      ign_cnt_r <= ign_cnt_r - UW'(1);
    end
  end

  // gate requests per state, then adaptive dead time
  always_comb begin
    hs_want = 1'b0;
    ls_want = 1'b0;
    case (state_nxt)
      ST_SOFTSTART, ST_RUN: begin
        hs_want = pwm_high_req;
        ls_want = pwm_low_req;
      end
      ST_LOCKOUT: ls_want = prot_live.dis && prot_live.over_voltage_trip;
      ST_CLAMP: ls_want = 1'b1;
      ST_OVP_TRIP: ls_want = 1'b1;
      default: ls_want = 1'b0;
    endcase
  end

  // sense lags the drive by the sync delay: opposite drive must be low that long
  assign hs_go = hs_want && ls_off_s && !ls_drive_r && (ls_hist_r == 3'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_drive_r <= 1'b0;
      ls_drive_r <= 1'b0;
      hs_hist_r  <= 3'h0;
      ls_hist_r  <= 3'h0;
    end else begin
      hs_drive_r <= hs_go;
      ls_drive_r <= ls_want && hs_off_s && !hs_drive_r && (hs_hist_r == 3'h0)
                    && !hs_go;
      hs_hist_r  <= {hs_hist_r[1:0], hs_drive_r};
      ls_hist_r  <= {ls_hist_r[1:0], ls_drive_r};
    end
  end

  // registered control outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modulator_en       <= 1'b0;
      reference_en       <= 1'b1;
      discharge_en       <= 1'b0;
      force_continuous   <= 1'b0;
      current_limit_step <= 3'h0;
    end else begin
      modulator_en       <= (state_nxt == ST_SOFTSTART) || (state_nxt == ST_RUN);
      reference_en       <= (state_nxt != ST_CLAMP);
      discharge_en       <= (state_nxt == ST_DISCHARGE);
      force_continuous   <= tif.active;
      current_limit_step <= (state_r == ST_SOFTSTART) ? phase_r + 3'h1 :
                            ((state_r == ST_RUN) ? 3'h5 : 3'h0);
    end
  end

  // power-good follows the window comparator in run, released while blanking, pulled on a fault or outside run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_pull_r      <= 1'b1;
      power_good_out <= 1'b0;
    end else begin
      power_good_out <= 1'b0;
      if (fault_nxt) begin
        pg_pull_r <= 1'b1;
      end else if (state_nxt != ST_RUN) begin
        pg_pull_r <= 1'b1;
      end else if (blank_act) begin
        pg_pull_r <= 1'b0;
      end else begin
        pg_pull_r <= !window_s;
      end
    end
  end

  // apb slave, zero wait after setup
  logic [31:0] status_w;
  logic        hit_ctrl, hit_status;
  assign hit_ctrl   = (paddr == `BSS_REG_CTRL);
  assign hit_status = (paddr == `BSS_REG_STATUS);
  assign status_w   = {19'h0, pg_pull_r, blank_act, dis_r, cause_th_r, cause_uvp_r,
                       cause_ovp_r, fault_r, phase_r, state_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit_ctrl && !hit_status;
      if (psel && !penable && !pwrite) begin
        if (hit_ctrl) begin
          prdata <= {31'h0, ctrl_run_r};
        end else if (hit_status) begin
          prdata <= status_w;
        end else begin
          prdata <= 32'h00000000;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_run_r <= `BSS_CTRL_RUN_RST;
    end else if (psel && penable && pready && pwrite && hit_ctrl) begin
      ctrl_run_r <= pwdata[`BSS_CTRL_RUN_BIT];
    end
  end

  assign high_side_gate_drive = hs_drive_r;
  assign low_side_gate_drive  = ls_drive_r;
  assign power_good_oe        = pg_pull_r;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence step_edge_s;
    tif.load && blank_en;
  endsequence
  sequence blank_hold_s;
    blank_act [*8];
  endsequence

  gate_overlap_a: assert property (!(hs_drive_r && ls_drive_r))
    else $error("both gate drives high");
  hs_dead_time_a: assert property ($rose(hs_drive_r) |-> $past(ls_off_s) && !$past(ls_drive_r))
    else $error("high side on before low side off");
  ls_dead_time_a: assert property ($rose(ls_drive_r) |-> $past(hs_off_s) && !$past(hs_drive_r))
    else $error("low side on before high side off");
  lockout_inhibit_a: assert property (state_r == ST_LOCKOUT |-> !hs_drive_r && !modulator_en)
    else $error("switching during lockout");
  softstart_pg_a: assert property (state_r == ST_SOFTSTART |-> pg_pull_r)
    else $error("power good released in soft start");
  fault_pg_a: assert property (fault_r && $past(fault_r) |-> pg_pull_r)
    else $error("power good released with fault");
  ovp_react_a: assert property (ovp_hit |=> state_r == ST_OVP_TRIP && fault_r && !hs_drive_r)
    else $error("overvoltage not acted on");
  phase_step_a: assert property (state_r == ST_SOFTSTART && state_nxt == ST_SOFTSTART
      && ph_cnt_r == PW'(PHASE_CYC - 1) && phase_r < `BSS_LAST_PHASE
      |=> phase_r == $past(phase_r) + 3'h1)
    else $error("soft start phase did not advance");
  blank_window_a: assert property (step_edge_s |=> blank_hold_s)
    else $error("blanking shorter than expected");
  clamp_ref_a: assert property (state_r == ST_CLAMP && $past(state_r) == ST_CLAMP
      |-> !reference_en)
    else $error("reference on while clamped");
  uv_ignore_a: assert property (start_go |=> !uvp_hit [*8])
    else $error("undervoltage acted on during ignore time");
endmodule
`default_nettype wire

// file: sim/bss_gate_sense.sv
// gate sense model of one external power switch
`default_nettype none
module bss_gate_sense (
  input  wire logic pclk,
  input  wire logic drive,
  input  wire logic slow,
  output logic      sensed_off
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] wait_r;
  initial begin
    wait_r = 3'h0;
    sensed_off = 1'b1;
  end
  // gate charge lingers a few cycles after drive falls
  always @(posedge pclk) begin
    if (drive === 1'b1) begin
      wait_r <= slow ? 3'h5 : 3'h1;
      sensed_off <= 1'b0;
    end else if (wait_r != 3'h0) begin
      wait_r <= wait_r - 3'h1;
    end else begin
      sensed_off <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the buck supervisor sequencer
`include "bss_defs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bss_pkg::*;
  localparam int unsigned PH  = 20;
  localparam int unsigned UVI = 50;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sd_req_n, sup_ok, step_in, in_reg, win_ok, ov_in, uv_in, clamp_in;
  logic        hot_in, hs_off, ls_off, pwm_h, pwm_l, hs, ls, pg, pg_oe, slow;
  logic        mod_en, ref_en, dis_en, fc;
  logic [1:0]  prot_sel, blank_sel;
  logic [2:0]  lim;
  int          err_total, n_compared, hs_seen, n;

  bss_top #(.PHASE_CYC(PH), .UV_IGN_CYC(UVI)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shutdown_request_n(sd_req_n), .supply_ok_in(sup_ok), .level_step_in(step_in),
    .protection_select(prot_sel), .blanking_select(blank_sel), .in_regulation_in(in_reg),
    .window_ok_in(win_ok), .over_voltage_in(ov_in), .under_voltage_in(uv_in),
    .below_clamp_in(clamp_in), .thermal_fault_in(hot_in), .high_side_off_in(hs_off),
    .low_side_off_in(ls_off), .pwm_high_req(pwm_h), .pwm_low_req(pwm_l),
    .high_side_gate_drive(hs), .low_side_gate_drive(ls), .power_good_out(pg),
    .power_good_oe(pg_oe), .current_limit_step(lim), .modulator_en(mod_en),
    .reference_en(ref_en), .discharge_en(dis_en), .force_continuous(fc));
  bss_gate_sense hs_sense (.pclk(pclk), .drive(hs), .slow(slow), .sensed_off(hs_off));
  bss_gate_sense ls_sense (.pclk(pclk), .drive(ls), .slow(slow), .sensed_off(ls_off));

  always #25 pclk = ~pclk;

  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int unsigned k);
    repeat (k) @(posedge pclk);
  endtask

  function automatic int unsigned blank_cyc(input logic [1:0] s);
    case (s)
      2'h3: return 140 * `BSS_CLK_MHZ;
      2'h1: return 40 * `BSS_CLK_MHZ;
      default: return 90 * `BSS_CLK_MHZ;
    endcase
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int unsigned k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 20) begin
      err_total++;
      print_verdict();
    end
  endtask

  task automatic power_up(input logic [1:0] sel);
    presetn <= 1'b0;
    sup_ok <= 1'b0;
    prot_sel <= sel;
    {ov_in, uv_in, clamp_in, hot_in, in_reg, pwm_h, pwm_l} <= 7'h0;
    win_ok <= 1'b1;
    sd_req_n <= 1'b1;
    tick(6);
    presetn <= 1'b1;
    tick(8);
    chk({hs, ls, pg_oe, ref_en, mod_en}, {1'b0, sel[1], 3'b110});
    sup_ok <= 1'b1;
    tick(6);
    chk({lim, mod_en, pg_oe}, {3'h1, 2'b11});
  endtask

  always @(posedge pclk) begin
    if (presetn === 1'b1) begin
      chk({hs & ~ls_off, ls & ~hs_off, pg}, 3'h0);
      if (hs === 1'b1) hs_seen++;
    end
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, sd_req_n, sup_ok, step_in} = '0;
    {in_reg, win_ok, ov_in, uv_in, clamp_in, hot_in, pwm_h, pwm_l, slow} = '0;
    {paddr, pwdata, prot_sel, blank_sel} = '0;
    err_total = 0;
    n_compared = 0;
    hs_seen = 0;
    void'($urandom(32'h54AA74C9));
    @(posedge pclk);
    power_up(2'h3);
    for (int p = 2; p <= 5; p++) begin
      n = 0;
      while (lim !== 3'(p) && n < 40) begin
        tick(1);
        n++;
      end
      if (p < 5) chk(pg_oe, 1'b1);
      if (p > 2) chk(n >= PH && n <= PH + 1, 1'b1);
    end
    tick(6);
    chk(pg_oe, 1'b0);
    win_ok <= 1'b0;
    tick(6);
    chk(pg_oe, 1'b1);
    apb(1'b0, `BSS_REG_STATUS, 32'h0);
    chk(rd[2:0], ST_RUN);
    apb(1'b0, `BSS_REG_CTRL, 32'h0);
    chk(rd, `BSS_CTRL_RST);
    apb(1'b1, 8'h08, 32'hFFFFFFFF);
    chk(perr, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    chk({perr, rd[30:0]}, 32'h80000000);
    win_ok <= 1'b1;
    for (int i = 0; i < 200; i++) begin
      pwm_h <= 1'($urandom);
      pwm_l <= 1'($urandom);
      slow <= 1'($urandom);
      tick($urandom_range(8, 1));
    end
    pwm_h <= 1'b0;
    pwm_l <= 1'b0;
    chk(hs_seen > 0, 1'b1);
    win_ok <= 1'b0;
    for (int b = 3; b >= 0; b--) begin
      blank_sel <= 2'(b);
      tick(2);
      step_in <= ~step_in;
      n = 0;
      while (fc !== 1'b1 && n < 10) begin
        tick(1);
        n++;
      end
      if (n >= 10) err_total++;
      ov_in <= (b != 0);
      tick(20);
      chk({pg_oe, mod_en}, {b == 0, 1'b1});
      ov_in <= 1'b0;
      n = 20;
      while (fc === 1'b1 && n < 4000) begin
        tick(1);
        n++;
      end
      chk(n >= blank_cyc(b) && n <= blank_cyc(b) + 4, 1'b1);
    end
    win_ok <= 1'b1;
    slow <= 1'b1;
    ov_in <= 1'b1;
    tick(4);
    chk({hs, mod_en, pg_oe}, 3'b001);
    tick(12);
    chk(ls, 1'b1);
    ov_in <= 1'b0;
    tick(6);
    apb(1'b0, `BSS_REG_STATUS, 32'h0);
    chk({pg_oe, rd[7:6]}, 3'b111);
    sd_req_n <= 1'b0;
    tick(6);
    sd_req_n <= 1'b1;
    tick(8);
    apb(1'b0, `BSS_REG_STATUS, 32'h0);
    chk({rd[6], rd[2:0]}, {1'b0, ST_SOFTSTART});
    sd_req_n <= 1'b0;
    tick(8);
    chk({dis_en, ls, mod_en, ref_en, pg_oe}, 5'b10011);
    clamp_in <= 1'b1;
    tick(14);
    chk({ref_en, ls, hs}, 3'b010);
    power_up(2'h1);
    uv_in <= 1'b1;
    tick(UVI - 20);
    chk({dis_en, mod_en}, 2'b01);
    tick(30);
    chk({dis_en, mod_en, pg_oe}, 3'b101);
    power_up(2'h0);
    prot_sel <= 2'h3;
    apb(1'b1, `BSS_REG_CTRL, 32'h0);
    tick(8);
    chk({dis_en, ls, hs, mod_en}, 4'h0);
    apb(1'b0, `BSS_REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    in_reg <= 1'b1;
    apb(1'b1, `BSS_REG_CTRL, 32'h1);
    tick(8);
    apb(1'b0, `BSS_REG_STATUS, 32'h0);
    chk({lim, rd[2:0]}, {3'h5, ST_RUN});
    hot_in <= 1'b1;
    tick(8);
    apb(1'b0, `BSS_REG_STATUS, 32'h0);
    chk({dis_en, pg_oe, mod_en, rd[9]}, 4'b1101);
    print_verdict();
  end
endmodule
`default_nettype wire
